// File: core/bt8_pkg.sv
package bt8_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] BT8_IDX_CTRL1  = 6'h00;
    localparam logic [5:0] BT8_IDX_CTRL2  = 6'h01;
    localparam logic [5:0] BT8_IDX_SLAVE  = 6'h02;
    localparam logic [5:0] BT8_IDX_DMAEN  = 6'h03;
    localparam logic [5:0] BT8_IDX_IRQEN  = 6'h04;
    localparam logic [5:0] BT8_IDX_FLAGS  = 6'h05;
    localparam logic [5:0] BT8_IDX_EVGEN  = 6'h06;
    localparam logic [5:0] BT8_IDX_COUNT  = 6'h07;
    localparam logic [5:0] BT8_IDX_DIV    = 6'h08;
    localparam logic [5:0] BT8_IDX_RELOAD = 6'h09;
    localparam int         BT8_ADDR_W     = 8;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BT8_RUN_BIT    = 0;
    localparam int BT8_INHIB_BIT  = 1;
    localparam int BT8_SRC_BIT    = 2;
    localparam int BT8_SHOT_BIT   = 3;
    localparam int BT8_RBUF_BIT   = 7;
    localparam int BT8_MOS_LSB    = 4;
    localparam int BT8_SMF_LSB    = 0;
    localparam int BT8_TSEL_LSB   = 4;
    localparam int BT8_SYNC_BIT   = 7;
    localparam int BT8_UPD_BIT    = 0;
    localparam int BT8_TRG_BIT    = 6;

    // ------------------------------------------------------------
    // Writable masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] BT8_CTRL1_MASK = 8'h8F;
    localparam logic [7:0] BT8_CTRL2_MASK = 8'h70;
    localparam logic [7:0] BT8_SLAVE_MASK = 8'hF7;
    localparam logic [7:0] BT8_DMAEN_MASK = 8'h01;
    localparam logic [7:0] BT8_FLAG_MASK  = 8'h41;
    localparam logic [3:0] BT8_DIV_RST    = 4'h0;
    localparam logic [7:0] BT8_RELOAD_RST = 8'hFF;
    localparam logic [7:0] BT8_ZERO8      = 8'h00;

    // ------------------------------------------------------------
    // Mode codes
    // ------------------------------------------------------------
    localparam logic [2:0] BT8_MOS_SWUPD  = 3'h0;
    localparam logic [2:0] BT8_MOS_ENABLE = 3'h1;
    localparam logic [2:0] BT8_MOS_UPDATE = 3'h2;
    localparam logic [2:0] BT8_SMF_OFF    = 3'h0;
    localparam logic [2:0] BT8_SMF_RESET  = 3'h4;
    localparam logic [2:0] BT8_SMF_GATED  = 3'h5;
    localparam logic [2:0] BT8_SMF_START  = 3'h6;
    localparam logic [2:0] BT8_SMF_EXTCLK = 3'h7;

endpackage

// File: core/bt8_timer.sv
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
// Function
// - Eight-bit up counter wrapping to zero after the reload value, advancing per tick.
// - Sixteen-bit prescaler divides by two to the four-bit value.
// - Prescaler input is counter run, or trigger level (gated) or trigger rising edge (external clock).
// - Division value preloaded separately; reads return the preload copy.
// - Active division value refreshed from preload only at update events.
// - Reload buffering bit chooses direct or update-loaded reload value.
// - Single shot clears counter run at next update event.
// - Update source bit limits update request to overflow only.
// - Update inhibit blocks update events; software update still reinits.
// - Slave mode off: prescaler runs from clock while counter run set.
// - Master output select drives trigger output: update req, enable, event.
// - Enable output is run OR gated trigger, lagging unless sync delay.
// - Sync delay bit delays trigger input effects for aligned timers.
// - Trigger select picks one of four internal triggers; others reserved.
// - Reset mode: trigger rising edge reinits counter and updates registers.
// - Gated mode: counts only while trigger high, halts without clearing.
// - Start mode: trigger rising edge sets counter run, no reset.
// - External clock mode: trigger rising edges clock the counter.
// - Update DMA request follows update flag conditions when enabled.
// - Update and trigger interrupts, each flag gated by its enable bit.
// - Trigger flag set on active edge, both edges gated; write 0 clears.
// - Update flag set on overflow or reinit (software or reset-mode trigger) per source/inhibit.
// - Software update request reinits counter and prescaler, self-clearing.
// - Software trigger request sets trigger flag, self-clearing.
module bt8_timer
    import bt8_pkg::*;
(
    input  wire logic                          clk_i,        // System clock
    input  wire logic                          sys_rst_i,    // Sync reset
    input  wire logic                          psel_i,       // APB select
    input  wire logic                          penable_i,    // APB enable
    input  wire logic                          pwrite_i,     // APB write
    input  wire logic [bt8_pkg::BT8_ADDR_W-1:0] paddr_i,     // APB address
    input  wire logic [31:0]                   pwdata_i,     // APB wdata
    output logic      [31:0]                   prdata_o,     // APB rdata
    output logic                               pready_o,     // APB ready
    output logic                               pslverr_o,    // APB error
    input  wire logic [3:0]                    internal_trigger_i, // Peers
    output logic                               trigger_output_o,   // To peers
    output logic                               update_irq_o, // Update irq
    output logic                               trigger_irq_o,// Trigger irq
    output logic                               update_dma_o  // DMA pulse
);
    import bt8_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]  ctrl1_reg,  ctrl1_next;
    logic [7:0]  ctrl2_reg,  ctrl2_next;
    logic [7:0]  slave_reg,  slave_next;
    logic [7:0]  dmaen_reg,  dmaen_next;
    logic [7:0]  irqen_reg,  irqen_next;
    logic [7:0]  flags_reg,  flags_next;
    logic [7:0]  count_reg,  count_next;
    logic [15:0] pcnt_reg,   pcnt_next;
    logic [3:0]  divpre_reg, divpre_next;
    logic [3:0]  divact_reg, divact_next;
    logic [7:0]  relpre_reg, relpre_next;
    logic [7:0]  relact_reg, relact_next;
    logic        trgprev_reg, trgprev_next;
    logic        rised_reg,  rised_next;
    logic        falld_reg,  falld_next;
    logic        lvld_reg,   lvld_next;
    logic        enprev_reg, enprev_next;
    logic        trigger_output_reg,   trigger_output_next;
    logic        uirq_reg,   uirq_next;
    logic        tirq_reg,   tirq_next;
    logic        dma_reg,    dma_next;
    logic        ready_reg,  ready_next;
    logic        err_reg,    err_next;
    logic [31:0] rdata_reg,  rdata_next;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic [5:0] idx;
    logic       mapped;
    logic       wr;
    logic [7:0] wd;
    logic [7:0] rd;

    assign idx    = paddr_i[BT8_ADDR_W-1:2];
    assign mapped = (paddr_i[1:0] == 2'h0) && (idx <= BT8_IDX_RELOAD);
    // Write lands at the edge where the access completes
    assign wr     = psel_i && penable_i && ready_reg && pwrite_i && mapped;
    assign wd     = pwdata_i[7:0];

    // Read mux; reserved bits are zero since only mask bits are stored
    always_comb begin
        case (idx)
            BT8_IDX_CTRL1:  rd = ctrl1_reg;
            BT8_IDX_CTRL2:  rd = ctrl2_reg;
            BT8_IDX_SLAVE:  rd = slave_reg;
            BT8_IDX_DMAEN:  rd = dmaen_reg;
            BT8_IDX_IRQEN:  rd = irqen_reg;
            BT8_IDX_FLAGS:  rd = flags_reg;
            BT8_IDX_COUNT:  rd = count_reg;
            BT8_IDX_DIV:    rd = {4'h0, divpre_reg};
            BT8_IDX_RELOAD: rd = relpre_reg;
            default:        rd = BT8_ZERO8;
        endcase
    end

    // One wait state; data and error captured as ready rises
    always_comb begin
        ready_next = psel_i && penable_i && !ready_reg;
        rdata_next = rdata_reg;
        err_next   = err_reg;
        if (ready_next) begin
            rdata_next = (mapped && !pwrite_i) ? {24'h0, rd} : 32'h0;
            err_next   = !mapped;
        end
    end

    // ------------------------------------------------------------
    // Trigger input selection and edges
    // ------------------------------------------------------------
    logic [2:0] tsel;
    logic [2:0] smf;
    logic       sync_delay;
    logic       trg_sel;
    logic       rise_now;
    logic       fall_now;
    logic       rise;
    logic       fall;
    logic       lvl;

    assign tsel       = slave_reg[BT8_TSEL_LSB +: 3];
    assign smf        = slave_reg[BT8_SMF_LSB +: 3];
    assign sync_delay = slave_reg[BT8_SYNC_BIT];
    // Reserved select codes give a quiet input
    assign trg_sel    = !tsel[2] && internal_trigger_i[tsel[1:0]];
    assign rise_now   = trg_sel && !trgprev_reg;
    assign fall_now   = !trg_sel && trgprev_reg;
    // Delayed copies keep linked timers aligned
    assign rise       = sync_delay ? rised_reg : rise_now;
    assign fall       = sync_delay ? falld_reg : fall_now;
    assign lvl        = sync_delay ? lvld_reg  : trg_sel;

    // ------------------------------------------------------------
    // Timer next state
    // ------------------------------------------------------------
    logic        sw_upd;
    logic        sw_trg;
    logic        run;
    logic        psc_in;
    logic [15:0] mask;
    logic        tick;
    logic        ovf;
    logic        reinit;
    logic        update_event;
    logic        set_uf;
    logic        set_tf;
    logic        en_now;

    always_comb begin
        ctrl1_next   = ctrl1_reg;
        ctrl2_next   = ctrl2_reg;
        slave_next   = slave_reg;
        dmaen_next   = dmaen_reg;
        irqen_next   = irqen_reg;
        flags_next   = flags_reg;
        count_next   = count_reg;
        pcnt_next    = pcnt_reg;
        divpre_next  = divpre_reg;
        divact_next  = divact_reg;
        relpre_next  = relpre_reg;
        relact_next  = relact_reg;
        trgprev_next = trg_sel;
        rised_next   = rise_now;
        falld_next   = fall_now;
        lvld_next    = trg_sel;
        sw_upd = 1'b0;
        sw_trg = 1'b0;
        // Software writes; reserved bits masked off
        if (wr) begin
            case (idx)
                BT8_IDX_CTRL1: ctrl1_next = wd & BT8_CTRL1_MASK;
                BT8_IDX_CTRL2: ctrl2_next = wd & BT8_CTRL2_MASK;
                BT8_IDX_SLAVE: slave_next = wd & BT8_SLAVE_MASK;
                BT8_IDX_DMAEN: dmaen_next = wd & BT8_DMAEN_MASK;
                BT8_IDX_IRQEN: irqen_next = wd & BT8_FLAG_MASK;
                BT8_IDX_FLAGS: flags_next = flags_reg & wd;
                BT8_IDX_EVGEN: begin
                    sw_upd = wd[BT8_UPD_BIT];
                    sw_trg = wd[BT8_TRG_BIT];
                end
                BT8_IDX_COUNT: count_next = wd;
                BT8_IDX_DIV:   divpre_next = wd[3:0];
                BT8_IDX_RELOAD: begin
                    relpre_next = wd;
                    if (!ctrl1_reg[BT8_RBUF_BIT]) begin
                        relact_next = wd;
                    end
                end
                default: ;
            endcase
        end
        run = ctrl1_reg[BT8_RUN_BIT];
        // Prescaler feed per slave mode
        case (smf)
            BT8_SMF_GATED:  psc_in = lvl;
            BT8_SMF_EXTCLK: psc_in = rise;
            default:        psc_in = run;
        endcase
        mask = 16'((32'h1 << divact_reg) - 32'h1);
        tick = psc_in && ((pcnt_reg & mask) == mask);
        if (psc_in) begin
            pcnt_next = tick ? 16'h0 : pcnt_reg + 16'h1;
        end
        ovf = tick && (count_reg == relact_reg);
        if (ovf) begin
            count_next = BT8_ZERO8;
        end else if (tick) begin
            count_next = count_reg + 8'h1;
        end
        reinit = sw_upd || (smf == BT8_SMF_RESET && rise);
        if (reinit) begin
            count_next = BT8_ZERO8;
            pcnt_next  = 16'h0;
        end
        update_event = (ovf || reinit) && !ctrl1_reg[BT8_INHIB_BIT];
        if (update_event) begin
            divact_next = divpre_next;
            if (ctrl1_reg[BT8_RBUF_BIT]) begin
                relact_next = relpre_next;
            end
            if (ctrl1_reg[BT8_SHOT_BIT]) begin
                ctrl1_next[BT8_RUN_BIT] = 1'b0;
            end
        end
        if (smf == BT8_SMF_START && rise) begin
            ctrl1_next[BT8_RUN_BIT] = 1'b1;
        end
        // Flag sets win over a same-cycle software clear
        set_uf = update_event && (ovf || !ctrl1_reg[BT8_SRC_BIT]);
        case (smf)
            BT8_SMF_RESET,
            BT8_SMF_START,
            BT8_SMF_EXTCLK: set_tf = rise;
            BT8_SMF_GATED:  set_tf = rise || fall;
            default:        set_tf = 1'b0;
        endcase
        if (set_uf) begin
            flags_next[BT8_UPD_BIT] = 1'b1;
        end
        if (set_tf || sw_trg) begin
            flags_next[BT8_TRG_BIT] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Output next values
    // ------------------------------------------------------------
    always_comb begin
        en_now = run || (smf == BT8_SMF_GATED && trg_sel);
        enprev_next = en_now;
        case (ctrl2_reg[BT8_MOS_LSB +: 3])
            BT8_MOS_SWUPD:  trigger_output_next = sw_upd;
            BT8_MOS_ENABLE: trigger_output_next = sync_delay ? en_now
                                                   : enprev_reg;
            BT8_MOS_UPDATE: trigger_output_next = update_event;
            default:        trigger_output_next = 1'b0;
        endcase
        uirq_next = flags_next[BT8_UPD_BIT]
                    && irqen_next[BT8_UPD_BIT];
        tirq_next = flags_next[BT8_TRG_BIT]
                    && irqen_next[BT8_TRG_BIT];
        dma_next  = set_uf && dmaen_reg[BT8_UPD_BIT];
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctrl1_reg   <= BT8_ZERO8;
            ctrl2_reg   <= BT8_ZERO8;
            slave_reg   <= BT8_ZERO8;
            dmaen_reg   <= BT8_ZERO8;
            irqen_reg   <= BT8_ZERO8;
            flags_reg   <= BT8_ZERO8;
            count_reg   <= BT8_ZERO8;
            pcnt_reg    <= 16'h0;
            divpre_reg  <= BT8_DIV_RST;
            divact_reg  <= BT8_DIV_RST;
            relpre_reg  <= BT8_RELOAD_RST;
            relact_reg  <= BT8_RELOAD_RST;
            trgprev_reg <= 1'b0;
            rised_reg   <= 1'b0;
            falld_reg   <= 1'b0;
            lvld_reg    <= 1'b0;
            enprev_reg  <= 1'b0;
            trigger_output_reg    <= 1'b0;
            uirq_reg    <= 1'b0;
            tirq_reg    <= 1'b0;
            dma_reg     <= 1'b0;
            ready_reg   <= 1'b0;
            err_reg     <= 1'b0;
            rdata_reg   <= 32'h0;
        end else begin
            ctrl1_reg   <= ctrl1_next;
            ctrl2_reg   <= ctrl2_next;
            slave_reg   <= slave_next;
            dmaen_reg   <= dmaen_next;
            irqen_reg   <= irqen_next;
            flags_reg   <= flags_next;
            count_reg   <= count_next;
            pcnt_reg    <= pcnt_next;
            divpre_reg  <= divpre_next;
            divact_reg  <= divact_next;
            relpre_reg  <= relpre_next;
            relact_reg  <= relact_next;
            trgprev_reg <= trgprev_next;
            rised_reg   <= rised_next;
            falld_reg   <= falld_next;
            lvld_reg    <= lvld_next;
            enprev_reg  <= enprev_next;
            trigger_output_reg    <= trigger_output_next;
            uirq_reg    <= uirq_next;
            tirq_reg    <= tirq_next;
            dma_reg     <= dma_next;
            ready_reg   <= ready_next;
            err_reg     <= err_next;
            rdata_reg   <= rdata_next;
        end
    end

    // Outputs straight from flops
    assign prdata_o         = rdata_reg;
    assign pready_o         = ready_reg;
    assign pslverr_o        = err_reg;
    assign trigger_output_o = trigger_output_reg;
    assign update_irq_o     = uirq_reg;
    assign trigger_irq_o    = tirq_reg;
    assign update_dma_o     = dma_reg;

endmodule

// File: bench/bt8_timer_asserts.sv
`timescale 1ns/10ps
// Port-level checker for the timer, attached by bind
module bt8_timer_asserts (
    input wire logic                          clk_i,              // Clock
    input wire logic                          sys_rst_i,          // Reset
    input wire logic                          psel_i,             // Select
    input wire logic                          penable_i,          // Enable
    input wire logic                          pwrite_i,           // Write
    input wire logic [bt8_pkg::BT8_ADDR_W-1:0] paddr_i,           // Address
    input wire logic [31:0]                   pwdata_i,           // Wdata
    input wire logic [31:0]                   prdata_o,           // Rdata
    input wire logic                          pready_o,           // Ready
    input wire logic                          pslverr_o,          // Error
    input wire logic [3:0]                    internal_trigger_i, // Peers
    input wire logic                          trigger_output_o,   // Out
    input wire logic                          update_irq_o,       // Irq
    input wire logic                          trigger_irq_o,      // Irq
    input wire logic                          update_dma_o        // DMA
);
    import bt8_pkg::*;
    localparam logic [7:0] A_FL = {BT8_IDX_FLAGS, 2'h0};
    logic [2:0] mos_reg;
    logic [2:0] mos_next;
    logic [1:0] ien_reg;
    logic [1:0] ien_next;
    logic       wr_done;
    logic       bad_addr;
    // Completed writes and addresses the block must refuse
    assign wr_done  = psel_i && penable_i && pready_o && pwrite_i;
    assign bad_addr = paddr_i[7:2] > BT8_IDX_RELOAD || paddr_i[1:0] != 2'h0;
    // Shadow copies of the master code and the interrupt enables
    always_comb begin
        mos_next = mos_reg;
        ien_next = ien_reg;
        if (wr_done && paddr_i == {BT8_IDX_CTRL2, 2'h0})
            mos_next = pwdata_i[6:4];
        if (wr_done && paddr_i == {BT8_IDX_IRQEN, 2'h0})
            ien_next = {pwdata_i[6], pwdata_i[0]};
    end
    // Shadow registers, cleared by reset
    always_ff @(posedge clk_i) begin
        mos_reg <= sys_rst_i ? 3'h0 : mos_next;
        ien_reg <= sys_rst_i ? 2'h0 : ien_next;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_wait; psel_i && penable_i && !pready_o; endsequence
    sequence s_done; psel_i && penable_i && pready_o; endsequence
    property p_setup_idle; psel_i && !penable_i |=> !pready_o; endproperty
    a_setup_idle: assert property (p_setup_idle) else $error("early ready");
    property p_one_wait; s_wait |=> s_done; endproperty
    a_one_wait: assert property (p_one_wait) else $error("ready late");
    property p_ready_once; pready_o |=> !pready_o; endproperty
    a_ready_once: assert property (p_ready_once) else $error("ready held");
    property p_bad_err; s_done ##0 bad_addr |-> pslverr_o; endproperty
    a_bad_err: assert property (p_bad_err) else $error("no error");
    property p_good_ok; s_done ##0 !bad_addr |-> !pslverr_o; endproperty
    a_good_ok: assert property (p_good_ok) else $error("spurious error");
    property p_rd_upper; pready_o |-> prdata_o[31:8] == 24'h0; endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper bits");
    property p_flag_rsv; s_done ##0 (!pwrite_i && paddr_i == A_FL)
        |-> (prdata_o[7:0] & ~BT8_FLAG_MASK) == 8'h00; endproperty
    a_flag_rsv: assert property (p_flag_rsv) else $error("flag bits");
    property p_upd_mask; !ien_reg[0] && !$past(ien_reg[0]) |-> !update_irq_o;
    endproperty
    a_upd_mask: assert property (p_upd_mask) else $error("upd irq");
    property p_trg_mask; !ien_reg[1] && !$past(ien_reg[1]) |-> !trigger_irq_o;
    endproperty
    a_trg_mask: assert property (p_trg_mask) else $error("trg irq");
    property p_mos_rsv; mos_reg > BT8_MOS_UPDATE
        && $past(mos_reg) > BT8_MOS_UPDATE |-> !trigger_output_o; endproperty
    a_mos_rsv: assert property (p_mos_rsv) else $error("out code");
endmodule
bind bt8_timer bt8_timer_asserts bt8_timer_asserts_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .internal_trigger_i(internal_trigger_i),
    .trigger_output_o(trigger_output_o), .update_irq_o(update_irq_o),
    .trigger_irq_o(trigger_irq_o), .update_dma_o(update_dma_o));

// File: bench/bt8_peer_model.sv
`timescale 1ns/10ps
// Peer timers: each drives its trigger output as commanded
module bt8_peer_model (
    input  wire logic       clk_i,     // System clock
    input  wire logic       sys_rst_i, // Sync reset
    input  wire logic [3:0] pulse_i,   // Trigger requests
    output logic      [3:0] trig_o     // Trigger outputs
);
    logic [3:0] trig_reg;
    logic [3:0] trig_next;
    // Low in reset, otherwise the requested levels
    always_comb begin
        trig_next = sys_rst_i ? 4'h0 : pulse_i;
    end
    // Lines change only just after a rising edge
    always_ff @(posedge clk_i) begin
        trig_reg <= trig_next;
    end
    assign trig_o = trig_reg;
endmodule

// File: bench/test_basic_timer_8bit.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
    failures++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
// Drives the timer over APB and through the peer model
module test_basic_timer_8bit;
    import bt8_pkg::*;
    localparam logic [7:0] A_C1 = {BT8_IDX_CTRL1, 2'h0};
    localparam logic [7:0] A_C2 = {BT8_IDX_CTRL2, 2'h0};
    localparam logic [7:0] A_SL = {BT8_IDX_SLAVE, 2'h0};
    localparam logic [7:0] A_DM = {BT8_IDX_DMAEN, 2'h0};
    localparam logic [7:0] A_IE = {BT8_IDX_IRQEN, 2'h0};
    localparam logic [7:0] A_FL = {BT8_IDX_FLAGS, 2'h0};
    localparam logic [7:0] A_EG = {BT8_IDX_EVGEN, 2'h0};
    localparam logic [7:0] A_CN = {BT8_IDX_COUNT, 2'h0};
    localparam logic [7:0] A_DV = {BT8_IDX_DIV, 2'h0};
    localparam logic [7:0] A_RL = {BT8_IDX_RELOAD, 2'h0};
    logic        clk_i = 1'b0, sys_rst_i = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pulse = 4'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, trg_out, upd_irq, trg_irq, dma;
    logic [3:0]  trig;
    logic [32:0] exp_q[$];
    logic [7:0]  msk [5] = '{BT8_CTRL1_MASK, BT8_CTRL2_MASK, BT8_SLAVE_MASK,
                             BT8_DMAEN_MASK, 8'h41};
    int          failures = 0, checks_done = 0, trg_cnt = 0, dma_cnt = 0;
    bt8_timer bt8_timer_i (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .internal_trigger_i(trig),
        .trigger_output_o(trg_out), .update_irq_o(upd_irq),
        .trigger_irq_o(trg_irq), .update_dma_o(dma));
    bt8_peer_model bt8_peer_model_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .pulse_i(pulse), .trig_o(trig));
    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;
    // One APB transfer; the expected answer is noted first
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [7:0] d, input logic [32:0] e);
        int n;
        exp_q.push_back(e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk_i);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge clk_i); n++; end while (pready !== 1'b1 && n < 50);
        if (n == 50) begin
            failures++;
            tally_and_finish();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] d);
        apb(1'b0, a, 8'h00, {25'h0, d});
    endtask
    // One-cycle pulse on a peer trigger line, then settle
    task automatic pulse_on(input int p);
        pulse <= 4'h1 << p;
        @(posedge clk_i);
        pulse <= 4'h0;
        repeat (3) @(posedge clk_i);
    endtask
    // Single-shot run from a cleared counter; n is cycles to the irq
    task automatic shot(output int n);
        wr(A_C1, 8'h02);
        wr(A_FL, 8'h00);
        wr(A_EG, 8'h01);
        rd(A_FL, 8'h00);
        wr(A_C1, 8'h0D);
        n = 0;
        while (upd_irq !== 1'b1 && n < 2000) begin @(posedge clk_i); n++; end
        rd(A_C1, 8'h0C);
        rd(A_CN, 8'h00);
        rd(A_FL, 8'h01);
    endtask
    task tally_and_finish;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Compares each completed access with the oldest note
    always @(posedge clk_i) begin
        logic [32:0] e;
        if (psel && penable && pready === 1'b1) begin
            e = exp_q.pop_front();
            if (pwrite) `CHK(pslverr, e[32])
            else `CHK({pslverr, prdata}, e)
        end
    end
    // Counts trigger output and DMA cycles
    always @(posedge clk_i) begin
        if (trg_out === 1'b1) trg_cnt <= trg_cnt + 1;
        if (dma === 1'b1) dma_cnt <= dma_cnt + 1;
    end
    // Cuts a hung run short
    initial begin
        #100000;
        failures++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        int i, j, k, c, t0, t1, t2, d0;
        i = $urandom(78226);
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        for (i = 0; i < 10; i++)
            rd({i[5:0], 2'h0}, i == 9 ? BT8_RELOAD_RST : 8'h00);
        apb(1'b0, 8'h28, 8'h00, {1'b1, 32'h0});
        apb(1'b1, 8'h01, 8'h5A, {1'b1, 32'h0});
        for (i = 0; i < 5; i++) begin
            wr({i[5:0], 2'h0}, 8'hFF);
            rd({i[5:0], 2'h0}, msk[i]);
            wr({i[5:0], 2'h0}, 8'h00);
        end
        wr(A_C1, 8'h04);
        for (i = 0; i < 3; i++) begin
            c = trg_cnt;
            wr(A_C2, {1'b0, i[2:0], 4'h0});
            wr(A_EG, 8'h01);
            repeat (3) @(posedge clk_i);
            `CHK(trg_cnt - c, i == 1 ? 0 : 1)
        end
        wr(A_C2, 8'h10);
        wr(A_C1, 8'h05);
        repeat (3) @(posedge clk_i);
        `CHK(trg_out, 1'b1)
        wr(A_C1, 8'h04);
        repeat (3) @(posedge clk_i);
        `CHK(trg_out, 1'b0)
        wr(A_C2, 8'h00);
        wr(A_IE, 8'h01);
        wr(A_RL, 8'h03);
        wr(A_DM, 8'h01);
        d0 = dma_cnt;
        shot(t0);
        wr(A_DV, 8'h02);
        rd(A_DV, 8'h02);
        shot(t1);
        `CHK(t1, t0)
        shot(t2);
        `CHK(t2, t0 + 12)
        `CHK(dma_cnt - d0, 3)
        wr(A_FL, 8'h00);
        wr(A_IE, 8'h40);
        wr(A_EG, 8'h40);
        rd(A_FL, 8'h40);
        `CHK(trg_irq, 1'b1)
        wr(A_FL, 8'h00);
        rd(A_FL, 8'h00);
        wr(A_DV, 8'h00);
        wr(A_C1, 8'h00);
        wr(A_EG, 8'h01);
        rd(A_FL, 8'h01);
        for (k = 0; k < 4; k++) begin
            j = (k + 1 + $urandom % 3) % 4;
            wr(A_C1, 8'h02);
            wr(A_FL, 8'h00);
            wr(A_SL, {k[0], k[2:0], 4'h6});
            pulse_on(j);
            rd(A_C1, 8'h02);
            pulse_on(k);
            rd(A_C1, 8'h03);
            rd(A_FL, 8'h40);
            wr(A_SL, 8'h00);
        end
        wr(A_C1, 8'h02);
        wr(A_EG, 8'h01);
        wr(A_SL, {5'h00, BT8_SMF_EXTCLK});
        repeat (5) pulse_on(0);
        rd(A_CN, 8'h01);
        wr(A_C1, 8'h00);
        wr(A_FL, 8'h00);
        wr(A_SL, {5'h00, BT8_SMF_RESET});
        pulse_on(0);
        rd(A_CN, 8'h00);
        rd(A_FL, 8'h41);
        wr(A_FL, 8'h00);
        wr(A_SL, {5'h00, BT8_SMF_GATED});
        repeat (3) pulse_on(0);
        rd(A_CN, 8'h03);
        rd(A_FL, 8'h40);
        tally_and_finish();
    end
endmodule
